// ### sclkpm_top.sv
// system clock selection, oscillator gating and operating mode control
// Operation
// - fast oscillator yields 32 MHz pwm clock and 16 MHz fast system clock
// - slow clock comes from the 32 kHz low speed oscillator
// - low speed oscillator also clocks watchdog and time base
// - select field picks fast, fast/2..fast/64, or slow clock
// - in slow running, clearing fast enable stops fast, divided and pwm clocks
// - six modes: fast and slow run cpu; sleep and three idles stop it
// - fast mode: cpu on divided fast clock; fast, slow and rc clocks on
// - slow mode: system clock is slow; fast clock follows its enable
// - halt with keep bits 0/1 and fast select: idle_slow_only, fast clock off
// - halt with both keep bits clear: sleep, only rc clock for watchdog
// - halt with fast keep set: idle_both_clocks or idle_fast_only by slow keep bit
// - select code 000 undivided, 001..110 divide by 2..64, 111 slow
// - enabling fast oscillator clears stable flag, sets it after 16 ticks
`timescale 1ns/1ns
module sclkpm_top
  import sclkpm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_fast_osc_tick,
  input  wire logic       i_pwm_osc_tick,
  input  wire logic       i_slow_osc_tick,
  input  wire logic [2:0] i_clock_select_field,
  input  wire logic       i_fast_osc_enable,
  input  wire logic       i_fast_osc_idle_keep,
  input  wire logic       i_slow_osc_idle_keep,
  input  wire logic       i_ctrl_we,
  input  wire logic       i_halt,
  input  wire logic       i_wake,
  output logic            o_fast_osc_run,
  output logic            o_fast_osc_stable_flag,
  output logic            o_pwm_clk_tick,
  output logic            o_fast_clk_tick,
  output logic            o_sys_clk_tick,
  output logic            o_slow_clk_tick,
  output logic            o_slow_rc_clk_tick,
  output logic            o_wdt_clk_tick,
  output logic            o_tbase_clk_tick,
  output logic            o_cpu_run,
  output logic [2:0]      o_mode
);
  sclkpm_mode_t mode_q;
  sclkpm_mode_t mode_d;
  logic [2:0]   sel_q;
  logic         fen_q;
  logic         fkeep_q;
  logic         skeep_q;
  logic [4:0]   stab_cnt_q;
  logic         stab_q;
  logic         run_prev_q;
  logic         sel_slow;
  logic         running;
  logic         fast_on;
  logic         slow_on;
  logic         sys_on;
  logic         fast_tick_g;
  logic         sys_tick;
  logic         tick_pwm_q;
  logic         tick_fast_q;
  logic         tick_sys_q;
  logic         tick_slow_q;
  logic         tick_rc_q;

  sclkpm_div_if dv ();

  // halt exit and run-mode choice both follow the select field
  function automatic sclkpm_mode_t run_mode(input logic slow_sel);
    return slow_sel ? SCLKPM_SLOW : SCLKPM_FAST;
  endfunction

  sclkpm_div u_div (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .d      (dv.div)
  );

  // control bits held with their power-on values; written as a group
  // one strobe takes all four fields, so no partial update can be seen
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sel_q   <= SCLKPM_SEL_RST;
      fen_q   <= SCLKPM_FEN_RST;
      fkeep_q <= SCLKPM_FKEEP_RST;
      skeep_q <= SCLKPM_SKEEP_RST;
    end else if (i_ctrl_we) begin
      sel_q   <= i_clock_select_field;
      fen_q   <= i_fast_osc_enable;
      fkeep_q <= i_fast_osc_idle_keep;
      skeep_q <= i_slow_osc_idle_keep;
    end
  end

  assign sel_slow = (sel_q == SCLKPM_SEL_SLOW);
  assign running  = (mode_q == SCLKPM_FAST) || (mode_q == SCLKPM_SLOW);

  // mode sequencing; wake takes priority so a halt and wake together stay running
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      SCLKPM_FAST, SCLKPM_SLOW: begin
        if (i_halt && !i_wake) begin
          if (!fkeep_q && !skeep_q) begin
            mode_d = SCLKPM_SLEEP;
          end else if (!fkeep_q) begin
            mode_d = SCLKPM_IDLE_SLOW_ONLY;
          end else if (skeep_q) begin
            mode_d = SCLKPM_IDLE_BOTH_CLOCKS;
          end else begin
            mode_d = SCLKPM_IDLE_FAST_ONLY;
          end
        end else begin
          mode_d = run_mode(sel_slow);
        end
      end
      SCLKPM_IDLE_SLOW_ONLY, SCLKPM_IDLE_BOTH_CLOCKS, SCLKPM_IDLE_FAST_ONLY, SCLKPM_SLEEP: begin
        if (i_wake) begin
          mode_d = run_mode(sel_slow);
        end
      end
      default: mode_d = SCLKPM_FAST;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_q <= SCLKPM_FAST;
    end else begin
      mode_q <= mode_d;
    end
  end

  // fast oscillator: forced on in fast mode so the cpu never loses its clock
  always_comb begin
    case (mode_q)
      SCLKPM_FAST:  fast_on = 1'b1;
      SCLKPM_SLOW:  fast_on = fen_q;
      SCLKPM_IDLE_BOTH_CLOCKS: fast_on = 1'b1;
      SCLKPM_IDLE_FAST_ONLY: fast_on = 1'b1;
      SCLKPM_IDLE_SLOW_ONLY: fast_on = 1'b0;
      SCLKPM_SLEEP: fast_on = 1'b0;
      default:      fast_on = 1'b0;
    endcase
  end

  // slow clock to peripherals: stopped only where the slow keep bit is clear
  always_comb begin
    case (mode_q)
      SCLKPM_FAST:  slow_on = 1'b1;
      SCLKPM_SLOW:  slow_on = 1'b1;
      SCLKPM_IDLE_SLOW_ONLY: slow_on = 1'b1;
      SCLKPM_IDLE_BOTH_CLOCKS: slow_on = 1'b1;
      SCLKPM_IDLE_FAST_ONLY: slow_on = 1'b0;
      SCLKPM_SLEEP: slow_on = 1'b0;
      default:      slow_on = 1'b0;
    endcase
  end

  // system clock gate: an idle mode keeps it only while its source stays up
  always_comb begin
    case (mode_q)
      SCLKPM_FAST:  sys_on = 1'b1;
      SCLKPM_SLOW:  sys_on = 1'b1;
      SCLKPM_IDLE_SLOW_ONLY: sys_on = sel_slow;
      SCLKPM_IDLE_BOTH_CLOCKS: sys_on = 1'b1;
      SCLKPM_IDLE_FAST_ONLY: sys_on = !sel_slow;
      SCLKPM_SLEEP: sys_on = 1'b0;
      default:      sys_on = 1'b0;
    endcase
  end

  assign fast_tick_g  = fast_on && i_fast_osc_tick;
  assign dv.fast_tick = fast_tick_g;
  assign dv.sel       = sel_q;
  // slow select takes the slow oscillator; otherwise the prescaled fast clock
  assign sys_tick     = sys_on && (sel_slow ? i_slow_osc_tick : dv.div_tick);

  // stable flag: restart on every off-to-on edge of the fast oscillator
  // software must wait for it before moving the cpu onto a restarted fast clock
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      run_prev_q <= 1'b0;
      stab_cnt_q <= '0;
      stab_q     <= 1'b0;
    end else begin
      run_prev_q <= fast_on;
      if (!fast_on || !run_prev_q) begin
        stab_cnt_q <= '0;
        stab_q     <= 1'b0;
      end else if (fast_tick_g && !stab_q) begin
        stab_cnt_q <= stab_cnt_q + 1'b1;
        stab_q     <= (stab_cnt_q + 1'b1) == SCLKPM_STABLE_TICKS;
      end
    end
  end

  // outputs retimed so every clock tick leaves on a flop
  // one cycle of latency is the price of glitch-free gated ticks
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tick_pwm_q  <= 1'b0;
      tick_fast_q <= 1'b0;
      tick_sys_q  <= 1'b0;
      tick_slow_q <= 1'b0;
      tick_rc_q   <= 1'b0;
    end else begin
      tick_pwm_q  <= fast_on && i_pwm_osc_tick;
      tick_fast_q <= fast_tick_g;
      tick_sys_q  <= sys_tick;
      tick_slow_q <= slow_on && i_slow_osc_tick;
      tick_rc_q   <= i_slow_osc_tick;
    end
  end

  assign o_fast_osc_run         = fast_on;
  assign o_fast_osc_stable_flag = stab_q;
  assign o_pwm_clk_tick         = tick_pwm_q;
  assign o_fast_clk_tick        = tick_fast_q;
  assign o_sys_clk_tick         = tick_sys_q;
  assign o_slow_clk_tick        = tick_slow_q;
  assign o_slow_rc_clk_tick     = tick_rc_q;
  assign o_wdt_clk_tick         = tick_rc_q;
  assign o_tbase_clk_tick       = tick_rc_q;
  assign o_cpu_run              = running;
  assign o_mode                 = mode_q;
endmodule

// ### sclkpm_pkg.sv
// constants and types for the system clock and power mode block
package sclkpm_pkg;
  localparam logic [2:0] SCLKPM_SEL_FAST     = 3'h0;
  localparam logic [2:0] SCLKPM_SEL_SLOW     = 3'h7;
  localparam logic [2:0] SCLKPM_SEL_RST      = 3'h1;
  localparam logic       SCLKPM_FEN_RST      = 1'h1;
  localparam logic       SCLKPM_FKEEP_RST    = 1'h0;
  localparam logic       SCLKPM_SKEEP_RST    = 1'h0;
  localparam int         SCLKPM_PWM_MHZ      = 32;
  localparam int         SCLKPM_FAST_MHZ     = 16;
  localparam int         SCLKPM_SLOW_KHZ     = 32;
  localparam int         SCLKPM_DIV_MAX      = 64;
  localparam int         SCLKPM_DIV_W        = $clog2(SCLKPM_DIV_MAX);
  localparam logic [4:0] SCLKPM_STABLE_TICKS = 5'h10;

  typedef enum logic [2:0] {
    SCLKPM_FAST  = 3'h0,
    SCLKPM_SLOW  = 3'h1,
    SCLKPM_IDLE_SLOW_ONLY = 3'h3,
    SCLKPM_IDLE_BOTH_CLOCKS = 3'h2,
    SCLKPM_IDLE_FAST_ONLY = 3'h6,
    SCLKPM_SLEEP = 3'h7
  } sclkpm_mode_t;
endpackage

// ### sclkpm_div_if.sv
// carrier between the mode controller and the fast clock divider
`timescale 1ns/1ns
interface sclkpm_div_if;
  import sclkpm_pkg::*;
  logic       fast_tick;
  logic [2:0] sel;
  logic       div_tick;
  modport ctrl (output fast_tick, output sel, input div_tick);
  modport div  (input fast_tick, input sel, output div_tick);
endinterface

// ### sclkpm_div.sv
// fast clock prescaler, divide by 1 up to 64
`timescale 1ns/1ns
module sclkpm_div
  import sclkpm_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_srst,
  sclkpm_div_if.div  d
);
  logic [SCLKPM_DIV_W-1:0] cnt_q;
  logic [SCLKPM_DIV_W-1:0] mask;

  // a divide by 2^n tick fires when the low n count bits are all ones
  function automatic logic [SCLKPM_DIV_W-1:0] div_mask(input logic [2:0] sel);
    logic [SCLKPM_DIV_W:0] m;
    m = '0;
    m = (({{SCLKPM_DIV_W{1'b0}}, 1'b1}) << sel) - 1'b1;
    return m[SCLKPM_DIV_W-1:0];
  endfunction

  assign mask       = div_mask(d.sel);
  assign d.div_tick = d.fast_tick && ((cnt_q & mask) == mask);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q <= '0;
    end else if (d.fast_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// ### sclkpm_top_sva.sv
// assertions on the ports of the clock and power mode block
`timescale 1ns/1ns
module sclkpm_top_sva
  import sclkpm_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic       i_fast_osc_tick,
  input wire logic       i_slow_osc_tick,
  input wire logic       i_halt,
  input wire logic       i_wake,
  input wire logic       o_fast_osc_run,
  input wire logic       o_fast_osc_stable_flag,
  input wire logic       o_pwm_clk_tick,
  input wire logic       o_fast_clk_tick,
  input wire logic       o_sys_clk_tick,
  input wire logic       o_slow_clk_tick,
  input wire logic       o_slow_rc_clk_tick,
  input wire logic       o_wdt_clk_tick,
  input wire logic       o_tbase_clk_tick,
  input wire logic       o_cpu_run,
  input wire logic [2:0] o_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  rc_tick_a: assert property (i_slow_osc_tick |=> o_slow_rc_clk_tick && o_wdt_clk_tick)
    else $error("rc tick lost");
  cpu_run_a: assert property (o_cpu_run == (o_mode inside {SCLKPM_FAST, SCLKPM_SLOW}))
    else $error("cpu run wrong");
  halt_stop_a: assert property (o_cpu_run && i_halt && !i_wake |=> !o_cpu_run)
    else $error("halt ignored");
  fast_tick_a: assert property (
    o_mode == SCLKPM_FAST && i_fast_osc_tick |=> o_fast_clk_tick)
    else $error("fast tick lost");
  fast_run_a: assert property (
    o_mode inside {SCLKPM_FAST, SCLKPM_IDLE_BOTH_CLOCKS, SCLKPM_IDLE_FAST_ONLY} |-> o_fast_osc_run)
    else $error("fast osc off");
  fast_gate_a: assert property (!o_fast_osc_run |=> !o_fast_clk_tick && !o_pwm_clk_tick)
    else $error("fast tick leaked");
  sleep_gate_a: assert property (
    o_mode == SCLKPM_SLEEP |=> !o_sys_clk_tick && !o_slow_clk_tick)
    else $error("sleep tick leaked");
  flag_clear_a: assert property (!o_fast_osc_run |=> !o_fast_osc_stable_flag)
    else $error("stable flag stuck");
  wake_run_a: assert property (!o_cpu_run && i_wake |=> o_cpu_run)
    else $error("wake ignored");
  idle_gate_a: assert property (
    o_mode inside {SCLKPM_IDLE_SLOW_ONLY, SCLKPM_SLEEP} |-> !o_fast_osc_run)
    else $error("fast osc left on");
endmodule
bind sclkpm_top sclkpm_top_sva u_sva (.*);

// ### tb_sclkpm_top.sv
// self-checking bench for the clock and power mode block
`timescale 1ns/1ns
module tb_sclkpm_top;
  import sclkpm_pkg::*;
  logic i_clk = 0, i_srst = 1, i_fast_osc_tick = 0, i_pwm_osc_tick = 0, i_slow_osc_tick = 0;
  logic i_fast_osc_enable = 1, i_fast_osc_idle_keep = 0, i_slow_osc_idle_keep = 0;
  logic [2:0] i_clock_select_field = 3'h0, o_mode, k;
  logic i_ctrl_we = 0, i_halt = 0, i_wake = 0, full = 0, o_fast_osc_run, o_fast_osc_stable_flag;
  logic o_pwm_clk_tick, o_fast_clk_tick, o_sys_clk_tick, o_slow_clk_tick, o_slow_rc_clk_tick;
  logic o_wdt_clk_tick, o_tbase_clk_tick, o_cpu_run;
  int fails = 0, checks = 0, seed = 32'h5f411c21, n;
  sclkpm_top u_dut (.*);
  always #20 i_clk = ~i_clk;
  // ticks are random until the first count; from then on every oscillator cycle is present
  always @(posedge i_clk) begin
    #2;
    {i_fast_osc_tick, i_pwm_osc_tick, i_slow_osc_tick} = full ? 3'h7 : 3'($random(seed));
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge i_clk);
    #2;
  endtask
  task wr(input logic [2:0] s, input logic f, input logic fk, input logic sk);
    {i_clock_select_field, i_fast_osc_enable} = {s, f};
    {i_fast_osc_idle_keep, i_slow_osc_idle_keep} = {fk, sk};
    i_ctrl_we = 1;
    cyc(1);
    i_ctrl_we = 0;
  endtask
  function logic [2:0] idle_mode(input logic fk, input logic sk);
    return fk ? (sk ? SCLKPM_IDLE_BOTH_CLOCKS : SCLKPM_IDLE_FAST_ONLY) : (sk ? SCLKPM_IDLE_SLOW_ONLY : SCLKPM_SLEEP);
  endfunction
  task wrap_up;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    wrap_up;
  end
  initial begin
    cyc(20);
    i_srst = 0;
    cyc(1);
    chk({o_mode, o_cpu_run, o_fast_osc_run, o_fast_osc_stable_flag}, {SCLKPM_FAST, 3'h6});
    cyc(50);
    full = 1;
    for (int s = 0; s < 8; s++) begin
      wr(3'(s), 1, 0, 0);
      cyc(3);
      n = 0;
      repeat (128) begin
        cyc(1);
        n = n + (o_sys_clk_tick === 1'b1);
      end
      chk(8'(n), s == 7 ? 8'h80 : 8'(128 >> s));
      chk(o_mode, s == 7 ? SCLKPM_SLOW : SCLKPM_FAST);
      chk({o_fast_clk_tick, o_pwm_clk_tick, o_slow_clk_tick, o_slow_rc_clk_tick},
          8'hf);
      chk({o_wdt_clk_tick, o_tbase_clk_tick, o_fast_osc_stable_flag}, 8'h7);
    end
    wr(3'h7, 0, 0, 0);
    cyc(3);
    chk({o_fast_osc_run, o_fast_clk_tick, o_pwm_clk_tick, o_sys_clk_tick}, 8'h1);
    // the flag must stay low through the first 15 counted ticks after the restart
    wr(3'h7, 1, 0, 0);
    cyc(16);
    chk(o_fast_osc_stable_flag, 8'h0);
    cyc(3);
    chk(o_fast_osc_stable_flag, 8'h1);
    repeat (16) begin
      k = 3'($random(seed));
      wr(k[0] ? 3'h7 : 3'h0, 1, k[1], k[2]);
      {i_halt, i_wake} = 2'h3;
      cyc(1);
      chk(o_cpu_run, 8'h1);
      i_wake = 0;
      cyc(3);
      chk(o_mode, idle_mode(k[1], k[2]));
      chk({o_cpu_run, o_fast_osc_run, o_slow_clk_tick, o_slow_rc_clk_tick},
          {5'h0, k[1], k[2], 1'h1});
      chk(o_sys_clk_tick, k[2] ? (k[1] | k[0]) : (k[1] & !k[0]));
      {i_halt, i_wake} = 2'h1;
      cyc(1);
      i_wake = 0;
      chk({o_cpu_run, o_mode}, {1'h1, k[0] ? SCLKPM_SLOW : SCLKPM_FAST});
    end
    // second reset mid-run: select back to fast/2 and both keep bits clear
    i_srst = 1;
    cyc(2);
    i_srst = 0;
    cyc(1);
    chk({o_mode, o_cpu_run, o_fast_osc_run, o_fast_osc_stable_flag}, {SCLKPM_FAST, 3'h6});
    cyc(2);
    n = 0;
    repeat (64) begin
      cyc(1);
      n = n + (o_sys_clk_tick === 1'b1);
    end
    chk(8'(n), 8'h20);
    i_halt = 1;
    cyc(1);
    i_halt = 0;
    chk(o_mode, SCLKPM_SLEEP);
    wrap_up;
  end
endmodule
